// file: hw/pole_ident_pkg.sv
package pole_ident_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	// Register byte addresses
	localparam logic [7:0] OFS_AMPLITUDE  = 8'h00;
	localparam logic [7:0] OFS_RAMP_TIME  = 8'h04;
	localparam logic [7:0] OFS_LOOP_GAIN  = 8'h08;
	localparam logic [7:0] OFS_LOOP_RESET = 8'h0C;
	localparam logic [7:0] OFS_MAX_MOVE   = 8'h10;
	localparam logic [7:0] OFS_ABS_CUR    = 8'h14;
	localparam logic [7:0] OFS_MODE       = 8'h18;
	localparam logic [7:0] OFS_CONTROL    = 8'h1C;
	localparam logic [7:0] OFS_STATUS     = 8'h20;
	localparam logic [7:0] OFS_POLE_ANGLE = 8'h24;

	// Reset values and accepted ranges
	localparam logic [15:0] AMPLITUDE_RST  = 16'h0019;
	localparam logic [15:0] AMPLITUDE_MAX  = 16'h03E8;
	localparam logic [15:0] RAMP_TIME_RST  = 16'h000A;
	localparam logic [15:0] RAMP_TIME_MAX  = 16'h0258;
	localparam logic [15:0] LOOP_GAIN_RST  = 16'h0000;
	localparam logic [15:0] LOOP_GAIN_MAX  = 16'h03E8;
	localparam logic [15:0] LOOP_RESET_RST = 16'h0271;
	localparam logic [15:0] LOOP_RESET_MAX = 16'hEA60;
	localparam logic [15:0] MAX_MOVE_RST   = 16'h0014;
	localparam logic [15:0] MAX_MOVE_MAX   = 16'h005A;
	localparam logic [15:0] SETTING_MIN    = 16'h0001;
	localparam logic [15:0] MODE_RST       = 16'h0000;
	localparam logic [15:0] MODE_MIN_MOVE  = 16'h0006;

	// Scaling: amplitude percent to permille of rated current, 25 -> 350
	localparam logic [15:0] AMP_TO_PERMILLE = 16'h000E;
	localparam logic [31:0] PERMILLE_FULL   = 32'h0000_03E8;
	localparam logic [31:0] MS_PER_S        = 32'h0000_03E8;
	localparam logic [15:0] ANG_PER_DEG     = 16'h00B6;
	localparam int unsigned PLAUS_SHIFT     = 2;
	localparam logic [31:0] PERCENT_FULL    = 32'h0000_0064;
	localparam logic [31:0] TICK_IN_RESET   = 32'h0000_000A;

	// Timing
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned TICK_US     = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [15:0] DWELL_MS    = 16'h0064;
	localparam logic [15:0] SETTLE_MS   = 16'h00C8;

	// Control and status bit positions
	localparam int unsigned CTRL_ENABLE  = 0;
	localparam int unsigned CTRL_RELEASE = 1;
	localparam int unsigned ST_BUSY      = 0;
	localparam int unsigned ST_DONE      = 1;
	localparam int unsigned ST_MOVE      = 2;
	localparam int unsigned ST_PLAUS     = 3;
	localparam int unsigned ST_USER      = 4;
	localparam int unsigned ST_TRIP      = 5;
	localparam int unsigned ST_INHIBIT   = 6;

	typedef struct packed {
		logic [15:0] position;
		logic        util_trip;
		logic        overload_trip;
	} feedback_type;

	typedef struct packed {
		logic        enable;
		logic [15:0] current_pm;
		logic [15:0] angle;
	} drive_cmd_type;

	typedef enum logic [4:0] {
		S_IDLE     = 5'b00001,
		S_RAMP     = 5'b00010,
		S_DWELL    = 5'b00100,
		S_TEST_POS = 5'b01000,
		S_TEST_NEG = 5'b10000
	} state_type;

	function automatic logic [15:0] deg_to_ang(input logic [15:0] deg);
		logic [31:0] prod;
		prod = deg * ANG_PER_DEG;
		return prod[15:0];
	endfunction

	function automatic logic [15:0] ang_dist(input logic [15:0] a, input logic [15:0] b);
		logic signed [15:0] d;
		d = signed'(a - b);
		return (d < 0) ? 16'(-d) : 16'(d);
	endfunction

endpackage

// file: hw/position_hold_pi.sv
`timescale 1ns/1ns
module position_hold_pi (
	input  wire logic               clk_i,
	input  wire logic               arst_n_i,
	input  wire logic               clear_i,
	input  wire logic               tick_i,
	input  wire logic signed [15:0] err_i,
	input  wire logic [15:0]        gain_i,
	input  wire logic [15:0]        reset_time_i,
	output logic signed [15:0]      corr_o
);
	logic signed [31:0] integ;
	logic signed [31:0] next_integ;
	logic signed [31:0] p_term;
	logic signed [31:0] i_term;
	logic signed [31:0] sum;

	// Integral of error in ms units; reset time is in 0.1 ms units
	assign next_integ = integ + 32'(err_i);
	assign i_term     = (integ * signed'(pole_ident_pkg::TICK_IN_RESET))
	                    / signed'({16'h0000, reset_time_i});
	// Zero gain leaves a pure integrator
	assign p_term     = (32'(err_i) * signed'({16'h0000, gain_i}))
	                    / signed'(pole_ident_pkg::PERCENT_FULL);
	assign sum        = p_term + i_term;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			integ  <= '0;
			corr_o <= '0;
		end else if (clear_i) begin
			integ  <= '0;
			corr_o <= '0;
		end else if (tick_i) begin
			integ  <= next_integ;
			// Wraps like an angle, which is what the field angle wants
			corr_o <= sum[15:0];
		end
	end
endmodule // position_hold_pi

// file: hw/pole_angle_ident_min_move.sv
`timescale 1ns/1ns
// What this block does
// (R1) Start only with sync servo selected, no error; latch encoder position on enable.
// (R2) Default: current ramps linearly over 10 s to 35 % rated current.
// (R3) Position loop holds rotor at latched reference while current ramps.
// (R4) Movement over limit from reference raises error, measured value discarded.
// (R5) After final current and short dwell, apply positive then negative test angle.
// (R6) Rotor must follow each test angle within 25 %, else plausibility fails.
// (R7) Test angle magnitude equals the maximum permitted movement setting.
// (R8) Motion beyond maximum permitted cancels identification and raises fault response.
// (R9) Device must be error-free and switched on; motor must not be blocked.
// (R10) Host disables, writes mode 6, then enables to start.
// (R11) Inhibiting the controller aborts identification, stored settings untouched.
// (R12) On success inhibit controller automatically and store found pole angle.
// (R13) Automatic inhibit is released by a control word command.
// (R14) Amplitude setting 1 to 1000 percent, default 25 meaning 35 % rated.
// (R15) Ramp time 1 to 600 s, default 10, scales current rise rate.
// (R16) PI gain 0 to 1000 percent, default 0 giving pure integral action.
// (R17) PI reset time 0.1 to 6000.0 ms, default 62.5 ms.
// (R18) Maximum permitted movement 1 to 90 degrees, default 20.
// (R19) Settings change only while the inverter is inhibited.
// (R20) Read-only display of absolute identification current, 0.01 A units.
// (R21) Utilisation or motor overload trip aborts identification.
// (R22) Separate status for success, movement abort, plausibility failure, user abort.
module pole_angle_ident_min_move #(
	parameter int unsigned TICK_CYCLES = pole_ident_pkg::TICK_CYCLES
) (
	input  wire logic                          clk_i,
	input  wire logic                          arst_n_i,
	input  wire logic [7:0]                    addr_i,
	input  wire logic [15:0]                   wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic [15:0]                        rdata_o,
	input  wire pole_ident_pkg::feedback_type  fb_i,
	input  wire logic                          sync_servo_i,
	input  wire logic                          error_pending_i,
	input  wire logic [15:0]                   rated_current_i,
	output pole_ident_pkg::drive_cmd_type      cmd_o,
	output logic [15:0]                        pole_angle_o,
	output logic                               enabled_o,
	output logic                               fault_o,
	output logic                               busy_o
);
	pole_ident_pkg::state_type state;
	pole_ident_pkg::state_type next_state;

	logic [15:0] amplitude;
	logic [15:0] ramp_time;
	logic [15:0] loop_gain;
	logic [15:0] loop_reset;
	logic [15:0] max_move;
	logic [15:0] abs_current;
	logic [15:0] mode;
	logic        ctrl_enable;
	logic        auto_inhibit;
	logic [5:1]  sticky;
	logic        enabled_q;
	logic [15:0] ref_pos;
	logic [15:0] current;
	logic [31:0] frac;
	logic [15:0] wait_cnt;
	logic [15:0] hold_angle;
	logic [31:0] tick_cnt;
	logic        tick;

	// Millisecond enable for ramp, loop and waits
	assign tick = (tick_cnt == TICK_CYCLES - 1);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt <= '0;
		end else if (tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	// Register decode
	wire sel_amp    = (addr_i == pole_ident_pkg::OFS_AMPLITUDE);
	wire sel_ramp   = (addr_i == pole_ident_pkg::OFS_RAMP_TIME);
	wire sel_gain   = (addr_i == pole_ident_pkg::OFS_LOOP_GAIN);
	wire sel_reset  = (addr_i == pole_ident_pkg::OFS_LOOP_RESET);
	wire sel_move   = (addr_i == pole_ident_pkg::OFS_MAX_MOVE);
	wire sel_abs    = (addr_i == pole_ident_pkg::OFS_ABS_CUR);
	wire sel_mode   = (addr_i == pole_ident_pkg::OFS_MODE);
	wire sel_ctrl   = (addr_i == pole_ident_pkg::OFS_CONTROL);
	wire sel_status = (addr_i == pole_ident_pkg::OFS_STATUS);
	wire sel_pole   = (addr_i == pole_ident_pkg::OFS_POLE_ANGLE);

	// Settings only while inhibited; out of range writes are dropped
	wire cfg_wr     = wr_i & ~enabled_o; // see (R19)
	wire wd_ge1     = (wdata_i >= pole_ident_pkg::SETTING_MIN);
	wire wr_amp     = cfg_wr & sel_amp & wd_ge1
	                  & (wdata_i <= pole_ident_pkg::AMPLITUDE_MAX); // see (R14)
	wire wr_ramp    = cfg_wr & sel_ramp & wd_ge1
	                  & (wdata_i <= pole_ident_pkg::RAMP_TIME_MAX); // see (R15)
	wire wr_gain    = cfg_wr & sel_gain
	                  & (wdata_i <= pole_ident_pkg::LOOP_GAIN_MAX); // see (R16)
	wire wr_reset   = cfg_wr & sel_reset & wd_ge1
	                  & (wdata_i <= pole_ident_pkg::LOOP_RESET_MAX); // see (R17)
	wire wr_move    = cfg_wr & sel_move & wd_ge1
	                  & (wdata_i <= pole_ident_pkg::MAX_MOVE_MAX); // see (R18)
	wire wr_mode    = cfg_wr & sel_mode;
	wire wr_ctrl    = wr_i & sel_ctrl;
	wire wr_status  = wr_i & sel_status;
	wire release_rq = wr_ctrl & wdata_i[pole_ident_pkg::CTRL_RELEASE];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			amplitude  <= pole_ident_pkg::AMPLITUDE_RST;
			ramp_time  <= pole_ident_pkg::RAMP_TIME_RST;
			loop_gain  <= pole_ident_pkg::LOOP_GAIN_RST;
			loop_reset <= pole_ident_pkg::LOOP_RESET_RST;
			max_move   <= pole_ident_pkg::MAX_MOVE_RST;
			mode       <= pole_ident_pkg::MODE_RST;
		end else begin
			if (wr_amp)
				amplitude <= wdata_i;
			if (wr_ramp)
				ramp_time <= wdata_i;
			if (wr_gain)
				loop_gain <= wdata_i;
			if (wr_reset)
				loop_reset <= wdata_i;
			if (wr_move)
				max_move <= wdata_i;
			if (wr_mode)
				mode <= wdata_i;
		end
	end

	// Derived set points
	wire [31:0] target_full = amplitude * pole_ident_pkg::AMP_TO_PERMILLE;
	wire [15:0] target      = target_full[15:0]; // see (R2) (R14)
	wire [31:0] ramp_denom  = ramp_time * pole_ident_pkg::MS_PER_S; // see (R15)
	wire [31:0] abs_full    = (rated_current_i * target)
	                          / pole_ident_pkg::PERMILLE_FULL;
	wire [15:0] limit_ang   = pole_ident_pkg::deg_to_ang(max_move);
	wire [15:0] test_ang    = limit_ang; // see (R7)
	wire [15:0] plaus_tol   = test_ang >> pole_ident_pkg::PLAUS_SHIFT; // see (R6)

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			abs_current <= '0;
		end else begin
			abs_current <= abs_full[15:0]; // see (R20)
		end
	end

	// Effective enable and start condition
	wire busy       = (state != pole_ident_pkg::S_IDLE);
	wire enable_req = ctrl_enable & ~auto_inhibit;
	wire can_start  = (mode == pole_ident_pkg::MODE_MIN_MOVE) & sync_servo_i
	                  & ~error_pending_i & ~fault_o; // see (R1) (R9)
	wire start      = enable_req & ~enabled_q & can_start
	                  & (state == pole_ident_pkg::S_IDLE); // see (R10)

	// Abort causes while a run is in progress
	wire user_abort = busy & ~enable_req; // see (R11)
	wire trip_abort = busy & ~user_abort
	                  & (fb_i.util_trip | fb_i.overload_trip); // see (R21)
	wire holding    = (state == pole_ident_pkg::S_RAMP)
	                  | (state == pole_ident_pkg::S_DWELL);
	wire moved      = pole_ident_pkg::ang_dist(fb_i.position, ref_pos) > limit_ang;
	wire move_abort = holding & ~user_abort & ~trip_abort & moved; // see (R4) (R8)
	wire any_abort  = user_abort | trip_abort | move_abort;

	wire wait_done  = tick & (wait_cnt == pole_ident_pkg::DWELL_MS - 16'h0001);
	wire settled    = tick & (wait_cnt == pole_ident_pkg::SETTLE_MS - 16'h0001);
	wire [15:0] pos_target = hold_angle + test_ang;
	wire [15:0] neg_target = hold_angle - test_ang;
	wire [15:0] exp_pos    = ref_pos + test_ang;
	wire [15:0] exp_neg    = ref_pos - test_ang;
	wire pos_ok = pole_ident_pkg::ang_dist(fb_i.position, exp_pos) <= plaus_tol;
	wire neg_ok = pole_ident_pkg::ang_dist(fb_i.position, exp_neg) <= plaus_tol;
	wire plaus_fail = settled & ~any_abort
	                  & (((state == pole_ident_pkg::S_TEST_POS) & ~pos_ok)
	                  | ((state == pole_ident_pkg::S_TEST_NEG) & ~neg_ok)); // see (R6)
	wire success    = settled & ~any_abort & neg_ok
	                  & (state == pole_ident_pkg::S_TEST_NEG);

	// Ramp step: at most one permille per clock, plenty within a millisecond
	wire [31:0] frac_add  = tick ? {16'h0000, target} : 32'h0000_0000;
	wire        ramp_step = (frac >= ramp_denom) & (current < target);
	wire        ramp_end  = (current >= target);

	always_comb begin
		next_state = state;
		case (state)
			pole_ident_pkg::S_IDLE: begin
				if (start)
					next_state = pole_ident_pkg::S_RAMP;
			end
			pole_ident_pkg::S_RAMP: begin
				if (ramp_end)
					next_state = pole_ident_pkg::S_DWELL; // see (R5)
			end
			pole_ident_pkg::S_DWELL: begin
				if (wait_done)
					next_state = pole_ident_pkg::S_TEST_POS; // see (R5)
			end
			pole_ident_pkg::S_TEST_POS: begin
				if (settled)
					next_state = pole_ident_pkg::S_TEST_NEG;
			end
			pole_ident_pkg::S_TEST_NEG: begin
				if (settled)
					next_state = pole_ident_pkg::S_IDLE;
			end
			default: next_state = pole_ident_pkg::S_IDLE;
		endcase
		if (any_abort | plaus_fail)
			next_state = pole_ident_pkg::S_IDLE;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state     <= pole_ident_pkg::S_IDLE;
			enabled_q <= 1'b0;
		end else begin
			state     <= next_state;
			enabled_q <= enable_req;
		end
	end

	// Reference latch, ramp and waits
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_pos  <= '0;
			current  <= '0;
			frac     <= '0;
			wait_cnt <= '0;
		end else if (start) begin
			ref_pos  <= fb_i.position; // see (R1)
			current  <= '0;
			frac     <= '0;
			wait_cnt <= '0;
		end else if (!busy) begin
			current  <= '0;
		end else begin
			if (state == pole_ident_pkg::S_RAMP) begin
				frac    <= frac + frac_add - (ramp_step ? ramp_denom : 32'h0000_0000);
				current <= current + {15'h0000, ramp_step}; // see (R2)
			end
			if (state != next_state)
				wait_cnt <= '0;
			else if (tick)
				wait_cnt <= wait_cnt + 16'h0001;
		end
	end

	// Position loop holds the rotor on the reference
	logic signed [15:0] corr;
	wire signed [15:0] pos_err = signed'(ref_pos - fb_i.position);

	position_hold_pi u_hold (
		.clk_i        (clk_i),
		.arst_n_i     (arst_n_i),
		.clear_i      (start | ~busy),
		.tick_i       (tick & holding), // see (R3)
		.err_i        (pos_err),
		.gain_i       (loop_gain),
		.reset_time_i (loop_reset),
		.corr_o       (corr)
	);

	wire [15:0] loop_angle = ref_pos + corr;
	wire [15:0] field_angle = (state == pole_ident_pkg::S_TEST_POS) ? pos_target :
	                          (state == pole_ident_pkg::S_TEST_NEG) ? neg_target :
	                          loop_angle; // see (R3) (R5)

	// Offset between field and encoder, kept only for a good run
	wire [15:0] pole_meas = hold_angle - ref_pos;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_angle   <= '0;
			pole_angle_o <= '0;
			cmd_o        <= '0;
		end else begin
			if (state == pole_ident_pkg::S_DWELL && wait_done)
				hold_angle <= loop_angle;
			if (success)
				pole_angle_o <= pole_meas; // see (R12)
			cmd_o.enable     <= busy & ~any_abort & ~plaus_fail;
			cmd_o.current_pm <= (busy & ~any_abort) ? current : 16'h0000;
			cmd_o.angle      <= field_angle;
		end
	end

	// Control word, automatic inhibit and sticky outcome flags
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_enable  <= 1'b0;
			auto_inhibit <= 1'b0;
			sticky       <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_enable <= wdata_i[pole_ident_pkg::CTRL_ENABLE];
			// Set wins over a release in the same cycle
			if (success)
				auto_inhibit <= 1'b1; // see (R12)
			else if (release_rq)
				auto_inhibit <= 1'b0; // see (R13)
			sticky[pole_ident_pkg::ST_DONE]  <= success
				| (sticky[pole_ident_pkg::ST_DONE]
				& ~(wr_status & wdata_i[pole_ident_pkg::ST_DONE])); // see (R22)
			sticky[pole_ident_pkg::ST_MOVE]  <= move_abort
				| (sticky[pole_ident_pkg::ST_MOVE]
				& ~(wr_status & wdata_i[pole_ident_pkg::ST_MOVE])); // see (R4) (R22)
			sticky[pole_ident_pkg::ST_PLAUS] <= plaus_fail
				| (sticky[pole_ident_pkg::ST_PLAUS]
				& ~(wr_status & wdata_i[pole_ident_pkg::ST_PLAUS])); // see (R22)
			sticky[pole_ident_pkg::ST_USER]  <= user_abort
				| (sticky[pole_ident_pkg::ST_USER]
				& ~(wr_status & wdata_i[pole_ident_pkg::ST_USER])); // see (R22)
			sticky[pole_ident_pkg::ST_TRIP]  <= trip_abort
				| (sticky[pole_ident_pkg::ST_TRIP]
				& ~(wr_status & wdata_i[pole_ident_pkg::ST_TRIP]));
		end
	end

	// Fault response stays until software clears its cause
	assign fault_o   = sticky[pole_ident_pkg::ST_MOVE] | sticky[pole_ident_pkg::ST_PLAUS]
	                   | sticky[pole_ident_pkg::ST_TRIP]; // see (R8)
	assign enabled_o = enable_req;
	assign busy_o    = busy;

	wire [15:0] status_word = {9'h000, auto_inhibit, sticky, busy};
	wire [15:0] ctrl_word   = {14'h0000, 1'b0, ctrl_enable};
	wire [15:0] next_rdata  =
		!rd_i      ? 16'h0000    :
		sel_amp    ? amplitude   :
		sel_ramp   ? ramp_time   :
		sel_gain   ? loop_gain   :
		sel_reset  ? loop_reset  :
		sel_move   ? max_move    :
		sel_abs    ? abs_current :
		sel_mode   ? mode        :
		sel_ctrl   ? ctrl_word   :
		sel_status ? status_word :
		sel_pole   ? pole_angle_o :
		16'h0000;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= next_rdata;
		end
	end
endmodule // pole_angle_ident_min_move

// file: verification/pole_ident_asserts.sv
`timescale 1ns/1ns
module pole_ident_asserts (
	input wire logic                          clk_i,
	input wire logic                          arst_n_i,
	input wire pole_ident_pkg::feedback_type  fb_i,
	input wire logic                          sync_servo_i,
	input wire logic                          error_pending_i,
	input wire pole_ident_pkg::drive_cmd_type cmd_o,
	input wire logic [15:0]                   pole_angle_o,
	input wire logic                          enabled_o,
	input wire logic                          fault_o,
	input wire logic                          busy_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_start_gate: assert property ($rose(busy_o) |->
		$past(sync_servo_i) && !$past(error_pending_i)) else $error("start without servo");
	a_start_enable: assert property ($rose(busy_o) |-> $past(enabled_o))
		else $error("start without enable");
	a_ramp_step: assert property (busy_o && $past(busy_o) |->
		cmd_o.current_pm == $past(cmd_o.current_pm) ||
		cmd_o.current_pm == $past(cmd_o.current_pm) + 16'h0001) else $error("ramp jump");
	a_user_abort: assert property (busy_o && !enabled_o |-> ##[0:1] !busy_o)
		else $error("inhibit did not abort");
	a_trip_abort: assert property (
		busy_o && (fb_i.util_trip || fb_i.overload_trip) |-> ##[1:2] !busy_o)
		else $error("trip did not abort");
	a_fault_stops: assert property ($rose(fault_o) |->
		##[0:2] (!busy_o && !cmd_o.enable)) else $error("drive kept after fault");
	a_pole_success: assert property ($changed(pole_angle_o) |->
		##[0:1] (!busy_o && !enabled_o)) else $error("pole angle outside success");
	a_idle_no_drive: assert property (!busy_o && !$past(busy_o) |-> !cmd_o.enable)
		else $error("current while idle");

	cover property ($fell(busy_o) && !fault_o && !enabled_o);
	cover property ($rose(fault_o));
	cover property ($rose(busy_o));
endmodule // pole_ident_asserts

bind pole_angle_ident_min_move pole_ident_asserts u_pole_ident_asserts (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .fb_i(fb_i), .sync_servo_i(sync_servo_i),
	.error_pending_i(error_pending_i), .cmd_o(cmd_o), .pole_angle_o(pole_angle_o),
	.enabled_o(enabled_o), .fault_o(fault_o), .busy_o(busy_o)
);

// file: verification/motor_model.sv
`timescale 1ns/1ns
module motor_model (
	input  wire logic                          clk_i,
	input  wire pole_ident_pkg::drive_cmd_type cmd_i,
	input  wire logic [1:0]                    mode_i,
	input  wire logic [1:0]                    trip_i,
	output pole_ident_pkg::feedback_type       fb_o
);
	// Mode 0 follows the field 16 counts ahead, 1 blocked rotor, 2 rotor slips far off
	// The lead gives the hold loop a known correction to settle on
	logic [15:0] pos = 16'h1234;
	logic [15:0] a0 = 16'h0000;
	logic [15:0] p0 = 16'h0000;
	logic        en_q = 1'b0;

	always @(posedge clk_i) begin
		en_q <= cmd_i.enable;
		if (cmd_i.enable && !en_q) begin
			a0 <= cmd_i.angle;
			p0 <= pos;
		end else if (cmd_i.enable) begin
			case (mode_i)
				2'd0: pos <= p0 + cmd_i.angle - a0 + 16'h0010;
				2'd2: pos <= p0 + 16'h2000;
				default: pos <= pos;
			endcase
		end
	end
	// Trips come from the bench, standing in for the monitors
	assign fb_o = '{position: pos, util_trip: trip_i[0], overload_trip: trip_i[1]};
endmodule // motor_model

// file: verification/tb_pole_angle_ident_min_move.sv
`timescale 1ns/1ns
module tb_pole_angle_ident_min_move;
	localparam int unsigned TCK = 5;
	logic                          clk_i, arst_n_i, wr_i, rd_i, sync_servo_i, error_pending_i;
	logic [7:0]                    addr_i;
	logic [15:0]                   wdata_i, rdata_o, rated_current_i, pole_angle_o, v, peak;
	pole_ident_pkg::feedback_type  fb_i;
	pole_ident_pkg::drive_cmd_type cmd_o;
	logic                          enabled_o, fault_o, busy_o;
	logic [1:0]                    mot_mode, trip;
	int                            mismatches = 0, n_tests = 0, cycles = 0;
	logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	logic [15:0] rst [6] = '{16'h0019, 16'h000A, 16'h0000, 16'h0271, 16'h0014, 16'h015E};
	logic [15:0] bad [6] = '{16'h0000, 16'h0259, 16'h03E9, 16'h0000, 16'h005B, 16'h0001};
	logic [1:0]  fmode [5] = '{2'd0, 2'd0, 2'd0, 2'd2, 2'd1};
	logic [15:0] fst [5] = '{16'h0010, 16'h0020, 16'h0020, 16'h0004, 16'h0008};

	pole_angle_ident_min_move #(.TICK_CYCLES(TCK)) u_pole_angle_ident_min_move (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .fb_i(fb_i), .sync_servo_i(sync_servo_i),
		.error_pending_i(error_pending_i), .rated_current_i(rated_current_i), .cmd_o(cmd_o),
		.pole_angle_o(pole_angle_o), .enabled_o(enabled_o), .fault_o(fault_o), .busy_o(busy_o));
	motor_model u_motor_model (.clk_i(clk_i), .cmd_i(cmd_o), .mode_i(mot_mode), .trip_i(trip),
		.fb_o(fb_i));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cmd_o.current_pm > peak) peak = cmd_o.current_pm;
		if (cycles == 100000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// Bounded wait, the successful run takes the longest
	task automatic wait_idle();
		int i;
		i = 0;
		while (busy_o !== 1'b0 && i < 12000) begin
			@(posedge clk_i);
			#1 i++;
		end
		chk(16'(i < 12000), 16'h0001, "sequence hung");
	endtask

	initial begin
		arst_n_i = 1'b0;
		{wr_i, rd_i, addr_i, wdata_i, mot_mode, trip, error_pending_i} = '0;
		sync_servo_i = 1'b1;
		rated_current_i = 16'h03E8;
		peak = 16'h0000;
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(ofs[i], v);
			chk(v, rst[i], "reset value");
			wr(ofs[i], bad[i]);
			rd(ofs[i], v);
			chk(v, rst[i], "refused write");
		end
		rd(8'h30, v);
		chk(v, 16'h0000, "unmapped read");
		$display("test settings done");
		wr(8'h00, 16'h0001);
		wr(8'h04, 16'h0001);
		wr(8'h18, 16'h0006);
		rd(8'h14, v);
		chk(v, 16'h000E, "display current");
		for (int k = 0; k < 3; k++) begin
			sync_servo_i <= (k != 0);
			error_pending_i <= (k == 1);
			if (k == 2) wr(8'h18, 16'h0000);
			wr(8'h1C, 16'h0001);
			repeat (5) @(posedge clk_i);
			#1 chk(16'(busy_o), 16'h0000, "start not refused");
			wr(8'h1C, 16'h0000);
			if (k == 2) wr(8'h18, 16'h0006);
		end
		$display("test start_gate done");
		peak = 16'h0000;
		wr(8'h1C, 16'h0001);
		wr(8'h00, 16'h0005);
		rd(8'h00, v);
		chk(v, 16'h0001, "setting changed while enabled");
		wait_idle();
		rd(8'h20, v);
		chk(v, 16'h0042, "success status");
		chk(16'(enabled_o), 16'h0000, "no auto inhibit");
		chk(peak, 16'h000E, "final current");
		wr(8'h1C, 16'h0000);
		wr(8'h1C, 16'h0002);
		rd(8'h20, v);
		chk(v, 16'h0002, "inhibit not released");
		wr(8'h20, 16'h003E);
		// Loop cancels the model's 16 count lead, so the offset reads minus 16
		chk(pole_angle_o, 16'hFFF0, "pole angle stored");
		$display("test success done");
		for (int j = 0; j < 5; j++) begin
			mot_mode <= fmode[j];
			wr(8'h1C, 16'h0001);
			repeat (500) @(posedge clk_i);
			if (j == 0) wr(8'h1C, 16'h0000);
			if (j == 1 || j == 2) trip <= 2'(j);
			wait_idle();
			trip <= 2'b00;
			rd(8'h20, v);
			chk(v, fst[j], "abort status");
			chk(16'(fault_o), 16'(j != 0), "fault output");
			chk(pole_angle_o, 16'hFFF0, "pole angle not kept");
			rd(8'h00, v);
			chk(v, 16'h0001, "setting altered");
			wr(8'h1C, 16'h0000);
			wr(8'h20, 16'h003E);
			$display("test abort %0d done", j);
		end
		stop_test();
	end
endmodule // tb_pole_angle_ident_min_move
